// [design/pnc_pkg.sv]
// constants, field layouts and state types for the powered-node power controller
// assumes a 250 MHz core clock; registers sit behind an apb slave with 32-bit data
package pnc_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned INRUSH_WAIT_MS  = 10;
  localparam int unsigned INRUSH_WAIT_NS  = INRUSH_WAIT_MS * 1000000;
  // least time: round up to whole cycles
  localparam int unsigned INRUSH_CYCLES   = (INRUSH_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W           = 22;

  // register map (byte addresses)
  localparam int unsigned      ADDR_W       = 12;
  localparam logic [11:0]      OFS_CTRL     = 12'h000;
  localparam logic [11:0]      OFS_STATUS   = 12'h004;
  localparam logic [11:0]      OFS_IRQ_STAT = 12'h008;
  localparam logic [11:0]      OFS_IRQ_MASK = 12'h00C;

  // ctrl fields
  localparam int unsigned CTRL_REQ_EN   = 0;
  localparam int unsigned CTRL_TYPE_LSB = 1;
  localparam int unsigned CTRL_RESTART  = 3;

  // status fields
  localparam int unsigned ST_STATE_LSB  = 0;
  localparam int unsigned ST_REGION_LSB = 3;
  localparam int unsigned ST_MARK       = 5;
  localparam int unsigned ST_DISC       = 6;
  localparam int unsigned ST_HOLD       = 7;
  localparam int unsigned ST_LOAD       = 8;
  localparam int unsigned ST_INCOMPAT   = 9;

  // interrupt bits
  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_POWERED   = 0;
  localparam int unsigned IRQ_INCOMPAT  = 1;
  localparam int unsigned IRQ_LOST      = 2;
  localparam int unsigned IRQ_RESTART   = 3;

  // supported-source-type encodings
  localparam logic [1:0] SRC_CLASS0 = 2'h0;
  localparam logic [1:0] SRC_CLASS1 = 2'h1;
  localparam logic [1:0] SRC_MIXED  = 2'h2;

  // reset values
  localparam logic [1:0] SRC_RESET  = SRC_MIXED;

  typedef enum logic [2:0] {
    ST_UNPOWERED_IDLE,
    ST_DISCOVERY,
    ST_INRUSH_HOLDOFF,
    ST_POWERED,
    ST_INCOMPATIBLE
  } pnc_state_t;

  typedef enum logic [1:0] {
    RGN_DISCOVERY,
    RGN_CLASS0,
    RGN_CLASS1
  } pnc_region_t;

endpackage : pnc_pkg

// [design/pnc_tmr_if.sv]
// control and status wires between the node controller and its holdoff timer
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface pnc_tmr_if;
  logic clr;
  logic run;
  logic expired;

  modport ctl (output clr, output run, input expired);
  modport tmr (input clr, input run, output expired);
endinterface : pnc_tmr_if

// [design/pnc_sync3.sv]
// three-stage synchroniser with agreement filter for asynchronous pin levels
// assumes inputs are levels; a change is taken once stages two and three agree
`timescale 1ns/100ps
module pnc_sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pnc_sync_t;

  pnc_sync_t r_reg;
  pnc_sync_t r_next;

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = async_in;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    // s1 feeds only s2; the filter looks at s2 and s3
    for (int i = 0; i < W; i++) begin
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.q[i] = r_reg.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign sync_out = r_reg.q;

endmodule : pnc_sync3

// [design/pnc_tmr.sv]
// holdoff timer: cleared and stopped while clr is high, counts while run is high
// assumes clr and run come from registered controller state on the same clock
`timescale 1ns/100ps
module pnc_tmr #(
  parameter logic [pnc_pkg::TMR_W-1:0] LIMIT = pnc_pkg::TMR_W'(pnc_pkg::INRUSH_CYCLES)
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  pnc_tmr_if.tmr    t
);

  typedef struct packed {
    logic [pnc_pkg::TMR_W-1:0] cnt;
    logic                      exp;
  } pnc_tmr_t;

  pnc_tmr_t r_reg;
  pnc_tmr_t r_next;

  always_comb begin
    r_next = r_reg;
    if (t.clr) begin
      r_next = '0;
    end else if (t.run && !r_reg.exp) begin
      if (r_reg.cnt == LIMIT - pnc_pkg::TMR_W'(1)) begin
        r_next.exp = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + pnc_pkg::TMR_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign t.expired = r_reg.exp;

endmodule : pnc_tmr

// [design/pnc_node.sv]
// powered-node power controller: apb registers, trunk band qualification, signature and load enables
// assumes trunk comparators arrive as asynchronous levels; apb and restart on core_clk
//
// Notes on behaviour
// - low-class node takes only low-class source, high-class only high, mixed either
// - supported-source-type setting holds class 0 only, class 1 only, or mixed
// - restart input returns controller to unpowered idle from any state
// - request enable drives discovery and hold signature; disabled otherwise
// - mark-current enable output shows when mark behaviour is presented
// - discovery-current enable output shows when discovery behaviour is presented
// - hold-signature enable output applies the maintain-power signature
// - full-load enable only when enabled and ready for full power
// - each timer clears and stops on entering a state that stops it
// - inrush holdoff timer starts when voltage crosses the low-class threshold
// - no full load until threshold crossed and at least 10 ms elapsed
// - after the wait, full load allowed only in a compatible voltage band
// - incompatible band after the wait: stay below 500 uA and flag user
// - classify trunk voltage into discovery, class 0 and class 1 regions
// - while powered, hold signature drawn continuously, covering every qualifying interval
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
module pnc_node #(
  parameter int unsigned INRUSH_CYCLES = pnc_pkg::INRUSH_CYCLES
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pnc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // trunk comparators (asynchronous)
  input  wire logic                       above_low_class_threshold,
  input  wire logic                       above_high_class_threshold,
  // local restart from node logic
  input  wire logic                       restart,
  // signature and load controls
  output logic                            mark_current_en,
  output logic                            discovery_current_en,
  output logic                            hold_signature_en,
  output logic                            full_load_en,
  output logic                            incompatible_source,
  output logic                            irq
);

  typedef struct packed {
    pnc_pkg::pnc_state_t      st;
    logic                     req_en;
    logic [1:0]               src_type;
    logic                     restart_req;
    logic [pnc_pkg::IRQ_W-1:0] irq_stat;
    logic [pnc_pkg::IRQ_W-1:0] irq_mask;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
    logic                     mark;
    logic                     disc;
    logic                     hold;
    logic                     load;
    logic                     incompat;
    logic                     irq;
  } pnc_node_t;

  pnc_node_t r_reg;
  pnc_node_t r_next;

  logic [1:0]           cmp_sync;
  pnc_pkg::pnc_region_t region;
  logic                 compatible;
  logic                 restart_now;
  logic                 apb_setup;
  logic                 apb_write;
  logic [31:0]          rd_word;
  logic                 rd_hit;
  logic [pnc_pkg::IRQ_W-1:0] irq_ev;
  logic [pnc_pkg::IRQ_W-1:0] irq_clr;

  pnc_tmr_if tmr_bus ();

  pnc_sync3 #(
    .W (2)
  ) u_cmp_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in ({above_high_class_threshold, above_low_class_threshold}),
    .sync_out (cmp_sync)
  );

  pnc_tmr #(
    .LIMIT (pnc_pkg::TMR_W'(INRUSH_CYCLES))
  ) u_holdoff (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .t        (tmr_bus)
  );

  // band from the two comparators; high without low is taken as class 1
  always_comb begin
    if (cmp_sync[1]) begin
      region = pnc_pkg::RGN_CLASS1;
    end else if (cmp_sync[0]) begin
      region = pnc_pkg::RGN_CLASS0;
    end else begin
      region = pnc_pkg::RGN_DISCOVERY;
    end
  end

  // the unused type code 3 is treated as mixed so no setting locks the node out
  always_comb begin
    case (r_reg.src_type)
      pnc_pkg::SRC_CLASS0: compatible = (region == pnc_pkg::RGN_CLASS0);
      pnc_pkg::SRC_CLASS1: compatible = (region == pnc_pkg::RGN_CLASS1);
      default:             compatible = (region != pnc_pkg::RGN_DISCOVERY);
    endcase
  end

  // timer runs only in holdoff; every other state clears it, so entry always starts from zero
  assign tmr_bus.run = (r_reg.st == pnc_pkg::ST_INRUSH_HOLDOFF);
  assign tmr_bus.clr = (r_reg.st != pnc_pkg::ST_INRUSH_HOLDOFF);

  assign restart_now = restart | r_reg.restart_req;
  assign apb_setup   = psel & ~penable;
  assign apb_write   = psel & penable & r_reg.pready & pwrite;

  // read mux
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (paddr)
      pnc_pkg::OFS_CTRL: begin
        rd_word[pnc_pkg::CTRL_REQ_EN]                 = r_reg.req_en;
        rd_word[pnc_pkg::CTRL_TYPE_LSB +: 2]          = r_reg.src_type;
      end
      pnc_pkg::OFS_STATUS: begin
        rd_word[pnc_pkg::ST_STATE_LSB +: 3]           = r_reg.st;
        rd_word[pnc_pkg::ST_REGION_LSB +: 2]          = region;
        rd_word[pnc_pkg::ST_MARK]                     = r_reg.mark;
        rd_word[pnc_pkg::ST_DISC]                     = r_reg.disc;
        rd_word[pnc_pkg::ST_HOLD]                     = r_reg.hold;
        rd_word[pnc_pkg::ST_LOAD]                     = r_reg.load;
        rd_word[pnc_pkg::ST_INCOMPAT]                 = r_reg.incompat;
      end
      pnc_pkg::OFS_IRQ_STAT: begin
        rd_word[pnc_pkg::IRQ_W-1:0]                   = r_reg.irq_stat;
      end
      pnc_pkg::OFS_IRQ_MASK: begin
        rd_word[pnc_pkg::IRQ_W-1:0]                   = r_reg.irq_mask;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    r_next             = r_reg;
    irq_ev             = '0;
    irq_clr            = '0;
    r_next.restart_req = 1'b0;

    // apb: ready is raised for the first access cycle, so every transfer takes two cycles
    r_next.pready = apb_setup;
    if (apb_setup) begin
      r_next.prdata  = rd_word;
      r_next.pslverr = ~rd_hit;
    end else if (r_reg.pready) begin
      r_next.prdata  = '0;
      r_next.pslverr = 1'b0;
    end

    if (apb_write) begin
      case (paddr)
        pnc_pkg::OFS_CTRL: begin
          r_next.req_en      = pwdata[pnc_pkg::CTRL_REQ_EN];
          r_next.src_type    = pwdata[pnc_pkg::CTRL_TYPE_LSB +: 2];
          r_next.restart_req = pwdata[pnc_pkg::CTRL_RESTART];
        end
        pnc_pkg::OFS_IRQ_STAT: begin
          irq_clr = pwdata[pnc_pkg::IRQ_W-1:0];
        end
        pnc_pkg::OFS_IRQ_MASK: begin
          r_next.irq_mask = pwdata[pnc_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // controller sequence
    if (restart_now) begin
      r_next.st                       = pnc_pkg::ST_UNPOWERED_IDLE;
      irq_ev[pnc_pkg::IRQ_RESTART]    = 1'b1;
    end else if (!r_reg.req_en) begin
      r_next.st = pnc_pkg::ST_UNPOWERED_IDLE;
    end else begin
      case (r_reg.st)
        pnc_pkg::ST_UNPOWERED_IDLE: begin
          r_next.st = pnc_pkg::ST_DISCOVERY;
        end
        pnc_pkg::ST_DISCOVERY: begin
          if (region != pnc_pkg::RGN_DISCOVERY) begin
            r_next.st = pnc_pkg::ST_INRUSH_HOLDOFF;
          end
        end
        pnc_pkg::ST_INRUSH_HOLDOFF: begin
          if (region == pnc_pkg::RGN_DISCOVERY) begin
            r_next.st                  = pnc_pkg::ST_UNPOWERED_IDLE;
            irq_ev[pnc_pkg::IRQ_LOST]  = 1'b1;
          end else if (tmr_bus.expired) begin
            if (compatible) begin
              r_next.st                    = pnc_pkg::ST_POWERED;
              irq_ev[pnc_pkg::IRQ_POWERED] = 1'b1;
            end else begin
              r_next.st                     = pnc_pkg::ST_INCOMPATIBLE;
              irq_ev[pnc_pkg::IRQ_INCOMPAT] = 1'b1;
            end
          end
        end
        pnc_pkg::ST_POWERED: begin
          if (region == pnc_pkg::RGN_DISCOVERY) begin
            r_next.st                 = pnc_pkg::ST_UNPOWERED_IDLE;
            irq_ev[pnc_pkg::IRQ_LOST] = 1'b1;
          end else if (!compatible) begin
            // a band move under load is not trusted; load is dropped at once
            r_next.st                     = pnc_pkg::ST_INCOMPATIBLE;
            irq_ev[pnc_pkg::IRQ_INCOMPAT] = 1'b1;
          end
        end
        pnc_pkg::ST_INCOMPATIBLE: begin
          // leaving needs the trunk to fall away, so a new holdoff qualifies the next source
          if (region == pnc_pkg::RGN_DISCOVERY) begin
            r_next.st                 = pnc_pkg::ST_UNPOWERED_IDLE;
            irq_ev[pnc_pkg::IRQ_LOST] = 1'b1;
          end
        end
        default: begin
          r_next.st = pnc_pkg::ST_UNPOWERED_IDLE;
        end
      endcase
    end

    // outputs decoded from the next state so they change together with it
    r_next.mark     = (r_next.st == pnc_pkg::ST_DISCOVERY);
    r_next.disc     = (r_next.st == pnc_pkg::ST_DISCOVERY);
    // hold held on for the whole powered stay, which covers every qualifying interval
    r_next.hold     = (r_next.st == pnc_pkg::ST_POWERED);
    r_next.load     = (r_next.st == pnc_pkg::ST_POWERED);
    // in the incompatible state load and hold are off, leaving only the bias current
    r_next.incompat = (r_next.st == pnc_pkg::ST_INCOMPATIBLE);

    // sticky status: a new event wins over a clear in the same cycle
    r_next.irq_stat = (r_reg.irq_stat & ~irq_clr) | irq_ev;
    r_next.irq      = |(r_next.irq_stat & r_next.irq_mask);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r_reg          <= '0;
      r_reg.st       <= pnc_pkg::ST_UNPOWERED_IDLE;
      r_reg.src_type <= pnc_pkg::SRC_RESET;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign prdata               = r_reg.prdata;
  assign pready               = r_reg.pready;
  assign pslverr              = r_reg.pslverr;
  assign mark_current_en      = r_reg.mark;
  assign discovery_current_en = r_reg.disc;
  assign hold_signature_en    = r_reg.hold;
  assign full_load_en         = r_reg.load;
  assign incompatible_source  = r_reg.incompat;
  assign irq                  = r_reg.irq;

endmodule : pnc_node

// [test/pnc_src_model.sv]
// model of the trunk power source: sets which band the node's comparators see
// assumes the bench picks the band; the rail slews one band per STEP cycles
`timescale 1ns/100ps
module pnc_src_model #(
  parameter int unsigned STEP = 1
) (
  input  wire logic       core_clk,
  input  wire logic [1:0] band,
  output logic            above_low_class_threshold,
  output logic            above_high_class_threshold
);
  logic [1:0]  lvl_reg;
  int unsigned dwell_reg;

  initial begin
    lvl_reg = 2'h0;
    dwell_reg = 0;
  end

  // a real rail crosses the low threshold on its way to the high band
  always @(posedge core_clk) begin
    if (lvl_reg == band) begin
      dwell_reg <= 0;
    end else if (dwell_reg + 1 >= STEP) begin
      lvl_reg <= (lvl_reg < band) ? lvl_reg + 2'h1 : lvl_reg - 2'h1;
      dwell_reg <= 0;
    end else begin
      dwell_reg <= dwell_reg + 1;
    end
  end

  assign above_low_class_threshold  = (lvl_reg != 2'h0);
  assign above_high_class_threshold = (lvl_reg == 2'h2);
endmodule : pnc_src_model

// [test/pnc_node_asserts.sv]
// port assertions for the powered-node controller
// assumes one clock domain; bound to every pnc_node
`timescale 1ns/100ps
module pnc_node_asserts #(
  parameter int unsigned INRUSH_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic above_low_class_threshold,
  input wire logic restart,
  input wire logic mark_current_en,
  input wire logic discovery_current_en,
  input wire logic hold_signature_en,
  input wire logic full_load_en,
  input wire logic incompatible_source
);
  // cycles the trunk has stood above the low threshold; never shorter than the node's own view
  logic [31:0] thr_cnt_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n || !above_low_class_threshold) thr_cnt_reg <= 32'h0;
    else thr_cnt_reg <= thr_cnt_reg + 32'h1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence trunk_gone;
    !above_low_class_threshold [*6];
  endsequence
  sequence restart_seen;
    restart && ce;
  endsequence

  chk_restart_idle: assert property (restart_seen |=> !mark_current_en && !discovery_current_en
    && !hold_signature_en && !full_load_en && !incompatible_source) else $error("outputs active after restart");
  chk_sig_pair: assert property (mark_current_en == discovery_current_en)
    else $error("mark and discovery enables differ");
  chk_hold_load: assert property (hold_signature_en == full_load_en)
    else $error("hold signature and full load differ");
  chk_load_excl: assert property (full_load_en |-> !incompatible_source && !discovery_current_en)
    else $error("full load with another mode");
  chk_inrush_wait: assert property ($rose(full_load_en) |-> thr_cnt_reg >= INRUSH_CYCLES)
    else $error("full load before inrush wait");
  chk_incompat_wait: assert property ($rose(incompatible_source) |-> thr_cnt_reg >= INRUSH_CYCLES)
    else $error("incompatible flag before inrush wait");
  chk_trunk_drop: assert property (trunk_gone |=> !hold_signature_en && !full_load_en && !incompatible_source)
    else $error("powered state kept without trunk");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_apb_answer: assert property (psel && !penable && ce |=> pready)
    else $error("no answer after setup");
  chk_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule : pnc_node_asserts

bind pnc_node pnc_node_asserts #(.INRUSH_CYCLES(INRUSH_CYCLES)) u_pnc_node_asserts (
  .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .above_low_class_threshold(above_low_class_threshold), .restart(restart),
  .mark_current_en(mark_current_en), .discovery_current_en(discovery_current_en),
  .hold_signature_en(hold_signature_en), .full_load_en(full_load_en),
  .incompatible_source(incompatible_source)
);

// [test/pnc_node_tb.sv]
// self-checking bench for the powered-node controller
// assumes 250 MHz clock; inrush wait shortened to INRUSH cycles
`timescale 1ns/100ps
module pnc_node_tb;
  localparam int unsigned INRUSH = 20;
  typedef struct packed {logic [1:0] src; logic [1:0] band; logic [4:0] outs;} pnc_row_t;
  // outs = {mark, discovery, hold, load, incompatible}
  localparam pnc_row_t ROWS [8] = '{
    '{2'h0, 2'h1, 5'h06}, '{2'h0, 2'h2, 5'h01}, '{2'h1, 2'h1, 5'h01}, '{2'h1, 2'h2, 5'h06},
    '{2'h2, 2'h1, 5'h06}, '{2'h2, 2'h2, 5'h06}, '{2'h3, 2'h1, 5'h06}, '{2'h3, 2'h2, 5'h06}};

  logic        core_clk, rst_n, ce, psel, penable, pwrite, restart, pready, pslverr, err;
  logic        alow, ahigh, mark, disc, hold, load, incomp, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  band;
  int          num_errors, total_checks, n;

  pnc_node #(.INRUSH_CYCLES(INRUSH)) u_pnc_node (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .above_low_class_threshold(alow), .above_high_class_threshold(ahigh), .restart(restart),
    .mark_current_en(mark), .discovery_current_en(disc), .hold_signature_en(hold),
    .full_load_en(load), .incompatible_source(incomp), .irq(irq));
  pnc_src_model #(.STEP(2)) u_pnc_src_model (
    .core_clk(core_clk), .band(band), .above_low_class_threshold(alow), .above_high_class_threshold(ahigh));

  function automatic logic [31:0] outs();
    return {27'h0, mark, disc, hold, load, incomp};
  endfunction : outs

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // the slave answers in the first access cycle; a late answer is a mismatch, not a hang
    chk("apb answer", 32'h1, {31'h0, k == 1});
    @(posedge core_clk);
  endtask : apb

  // bounded wait for an output pattern, then compare; n holds the cycles waited
  task automatic expect_outs(input string what, input logic [31:0] exp);
    n = 0;
    while (outs() !== exp && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    chk(what, exp, outs());
  endtask : expect_outs

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("ERROR watchdog expected finish within %0d cycles seen timeout", 20000);
    print_verdict();
  end

  initial begin
    {psel, penable, pwrite, restart, paddr, pwdata, band} = '0;
    num_errors = 0;
    total_checks = 0;
    ce = 1'b1;
    rst_n = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    foreach (ROWS[i]) begin
      band <= 2'h0;
      apb(1'b1, pnc_pkg::OFS_CTRL, {29'h0, ROWS[i].src, 1'b1});
      expect_outs("discovery", 32'h18);
      apb(1'b1, pnc_pkg::OFS_IRQ_STAT, 32'hF);
      band <= ROWS[i].band;
      expect_outs("band outcome", {27'h0, ROWS[i].outs});
      chk("inrush wait", 32'h1, {31'h0, n > INRUSH});
      apb(1'b0, pnc_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irq status", ROWS[i].outs[0] ? 32'h2 : 32'h1, rd);
      apb(1'b0, pnc_pkg::OFS_STATUS, 32'h0);
      chk("region", {30'h0, ROWS[i].band}, (rd >> 3) & 32'h3);
      restart <= 1'b1;
      @(posedge core_clk);
      restart <= 1'b0;
      @(posedge core_clk);
      chk("restart", 32'h0, outs());
      $display("row %0d done", i);
    end
    // interrupt raised, cleared, then a masked event
    band <= 2'h0;
    apb(1'b1, pnc_pkg::OFS_IRQ_MASK, 32'h1);
    expect_outs("rediscover", 32'h18);
    apb(1'b1, pnc_pkg::OFS_IRQ_STAT, 32'hF);
    band <= 2'h1;
    expect_outs("powered", 32'h06);
    repeat (2) @(posedge core_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, pnc_pkg::OFS_IRQ_STAT, 32'h1);
    @(posedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    band <= 2'h0;
    expect_outs("trunk lost", 32'h18);
    apb(1'b0, pnc_pkg::OFS_IRQ_STAT, 32'h0);
    chk("lost status", 32'h4, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    // restart through the control bit: flagged in status, never read back as set
    apb(1'b1, pnc_pkg::OFS_CTRL, 32'hF);
    apb(1'b0, pnc_pkg::OFS_IRQ_STAT, 32'h0);
    chk("ctrl restart status", 32'hC, rd);
    apb(1'b0, pnc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl after restart", 32'h7, rd);
    $display("interrupt test done");
    // holdoff interrupted must start over
    band <= 2'h1;
    repeat (12) @(posedge core_clk);
    band <= 2'h0;
    expect_outs("holdoff abort", 32'h18);
    band <= 2'h1;
    expect_outs("holdoff again", 32'h06);
    chk("full wait again", 32'h1, {31'h0, n > INRUSH});
    // a restart pulse while the clock enable is low must leave the node powered
    ce <= 1'b0;
    restart <= 1'b1;
    repeat (3) @(posedge core_clk);
    restart <= 1'b0;
    @(posedge core_clk);
    ce <= 1'b1;
    @(posedge core_clk);
    chk("clock enable freeze", 32'h06, outs());
    apb(1'b1, pnc_pkg::OFS_CTRL, 32'h4);
    expect_outs("disabled", 32'h0);
    $display("holdoff and disable tests done");
    // reset in mid-run, then reset values and an unmapped address
    apb(1'b1, pnc_pkg::OFS_CTRL, 32'h1);
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("reset outputs", 32'h0, outs());
    apb(1'b0, pnc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h4, rd);
    apb(1'b0, pnc_pkg::OFS_IRQ_MASK, 32'h0);
    chk("mask reset", 32'h0, rd);
    apb(1'b1, 12'h010, 32'h1);
    chk("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped read", 32'h1, {31'h0, err} & {31'h0, rd == 32'h0});
    apb(1'b0, pnc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl untouched", 32'h4, rd);
    $display("reset and address tests done");
    print_verdict();
  end
endmodule : pnc_node_tb
